/* File: rtl/idio_top.sv */
// digital i/o ports: control in/out, internal, status and relay board word
`timescale 1ns/1ps
`default_nettype none
`include "idio_regs.svh"
module idio_top #(
  parameter int unsigned WD_CYCLES = `IDIO_WD_CYCLES
) (
  input  wire logic                  sys_clk,              // 40 mhz clock
  input  wire logic                  rstn,                 // async reset, low
  input  wire idio_pkg::idio_addr_t  io_addr,              // port address
  input  wire idio_pkg::idio_byte_t  io_wdata,             // write data
  input  wire logic                  io_wr,                // write strobe
  input  wire logic                  io_rd,                // read strobe
  output idio_pkg::idio_byte_t       io_rdata,             // read data
  output logic                       io_rvalid,            // read data valid
  input  wire logic [5:0]            ctrl_in_lo_n,         // inputs 1-6
  input  wire logic [5:0]            ctrl_in_hi_n,         // inputs 7-12
  input  wire idio_pkg::idio_byte_t  int_in,               // spare inputs
  output idio_pkg::idio_byte_t       ctrl_out_lo_n,        // outputs 1-8
  output logic [3:0]                 ctrl_out_hi_n,        // outputs 9-12
  output idio_pkg::idio_byte_t       int_out,              // spare outputs
  output logic                       healthy_flag_n,       // low when healthy
  output logic                       sequence_running_n,   // low in sequence
  output logic                       diagnostics_active_n, // low in diag mode
  output logic                       thermal_alarm_n,      // low on temp alarm
  output logic                       pressure_fault_n,     // low on press alarm
  output logic [2:0]                 status_a_spare,       // bits 7,6,1
  output idio_pkg::idio_byte_t       status_b,             // spare status byte
  input  wire logic                  relay_we,             // relay word write
  input  wire idio_pkg::idio_word_t  relay_wdata,          // relay word
  output idio_pkg::idio_word_t       relay_drive_n,        // relay drives
  output logic                       relay_wd_trip         // watchdog expired
);
  import idio_pkg::*;

  logic       hit_lo, hit_int, hit_sa, hit_sb, hit_hi;
  idio_byte_t out_lo_q, out_lo_d, int_out_q, int_out_d;
  logic [3:0] out_hi_q, out_hi_d;
  idio_byte_t rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  idio_byte_t status_a;

  always_comb begin
    hit_lo  = idio_hit(io_addr, `IDIO_ADDR_CTRL_LO);
    hit_int = idio_hit(io_addr, `IDIO_ADDR_INTERNAL);
    hit_sa  = idio_hit(io_addr, `IDIO_ADDR_STATUS_A);
    hit_sb  = idio_hit(io_addr, `IDIO_ADDR_STATUS_B);
    hit_hi  = idio_hit(io_addr, `IDIO_ADDR_CTRL_HI);
  end

  // output port registers; written values drive the pins unchanged
  always_comb begin
    out_lo_d  = (io_wr && hit_lo) ? io_wdata : out_lo_q;
    out_hi_d  = (io_wr && hit_hi) ? io_wdata[3:0] : out_hi_q;
    int_out_d = (io_wr && hit_int) ? io_wdata : int_out_q;
  end

  // outputs come up de-asserted so nothing external is driven before firmware runs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_lo_q  <= `IDIO_RST_OUT8;
      out_hi_q  <= `IDIO_RST_OUT4;
      int_out_q <= `IDIO_RST_OUT8;
    end else begin
      out_lo_q  <= out_lo_d;
      out_hi_q  <= out_hi_d;
      int_out_q <= int_out_d;
    end
  end

  // read path; status ports are write only and read as the unmapped value
  always_comb begin
    rvalid_d = io_rd;
    rdata_d  = rdata_q;
    if (io_rd) begin
      if (hit_lo) begin
        rdata_d = {`IDIO_IN_PAD, ctrl_in_lo_n};
      end else if (hit_hi) begin
        rdata_d = {`IDIO_IN_PAD, ctrl_in_hi_n};
      end else if (hit_int) begin
        rdata_d = int_in;
      end else begin
        rdata_d = `IDIO_UNMAPPED_RD;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q  <= `IDIO_UNMAPPED_RD;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  idio_wr_if #(.W(8))  st_a_if ();
  idio_wr_if #(.W(8))  st_b_if ();
  idio_wr_if #(.W(16)) rly_if ();

  assign st_a_if.we   = io_wr && hit_sa;
  assign st_a_if.data = io_wdata;
  assign st_b_if.we   = io_wr && hit_sb;
  assign st_b_if.data = io_wdata;
  assign rly_if.we    = relay_we;
  assign rly_if.data  = relay_wdata;

  idio_status u_status (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .wr_a     (st_a_if),
    .wr_b     (st_b_if),
    .status_a (status_a),
    .status_b (status_b)
  );

  idio_relay #(.WD_CYCLES(WD_CYCLES)) u_relay (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .wr         (rly_if),
    .drive      (relay_drive_n),
    .wd_tripped (relay_wd_trip)
  );

  assign io_rdata             = rdata_q;
  assign io_rvalid            = rvalid_q;
  assign ctrl_out_lo_n        = out_lo_q;
  assign ctrl_out_hi_n        = out_hi_q;
  assign int_out              = int_out_q;
  // firmware owns the meaning; the block only holds and drives the levels
  assign healthy_flag_n       = status_a[`IDIO_ST_HEALTHY];
  assign sequence_running_n   = status_a[`IDIO_ST_SEQ];
  assign diagnostics_active_n = status_a[`IDIO_ST_DIAG];
  assign thermal_alarm_n      = status_a[`IDIO_ST_THERMAL];
  assign pressure_fault_n     = status_a[`IDIO_ST_PRESSURE];
  assign status_a_spare       = {status_a[7:6], status_a[1]};

  property p_rd_lo;
    @(posedge sys_clk) disable iff (!rstn)
      (io_rd && hit_lo) |=> io_rvalid && io_rdata == {2'b11, $past(ctrl_in_lo_n)};
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("low input port read wrong");

  property p_rd_hi;
    @(posedge sys_clk) disable iff (!rstn)
      (io_rd && hit_hi) |=> io_rvalid && io_rdata[7:6] == 2'b11 &&
        io_rdata[5:0] == $past(ctrl_in_hi_n);
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high input port read wrong");

  property p_wr_lo;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_lo) |=> ctrl_out_lo_n == $past(io_wdata) ##1
        (ctrl_out_lo_n == $past(ctrl_out_lo_n) || $past(io_wr));
  endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("low output port not held");

  property p_wr_hi;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_hi) |=> ctrl_out_hi_n == $past(io_wdata[3:0]) && $stable(ctrl_out_lo_n);
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high output port write wrong");

  property p_internal;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_int) |=> int_out == $past(io_wdata) && $stable(ctrl_out_hi_n);
  endproperty
  a_internal: assert property (p_internal) else $error("internal output write wrong");

  property p_int_rd;
    @(posedge sys_clk) disable iff (!rstn)
      (io_rd && hit_int) |=> io_rdata == $past(int_in);
  endproperty
  a_int_rd: assert property (p_int_rd) else $error("internal input read wrong");

  property p_healthy;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_sa) |=> healthy_flag_n == $past(io_wdata[0]);
  endproperty
  a_healthy: assert property (p_healthy) else $error("healthy flag not driven");

  property p_sequence;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_sa && !io_wdata[2]) |=> !sequence_running_n;
  endproperty
  a_sequence: assert property (p_sequence) else $error("sequence flag not driven");

  property p_diag;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_sa) |=> diagnostics_active_n == $past(io_wdata[3]);
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic flag not driven");

  property p_thermal;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_sa) |=> thermal_alarm_n == $past(io_wdata[4]);
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal flag not driven");

  property p_pressure;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_sa) |=> pressure_fault_n == $past(io_wdata[5]) &&
        status_a_spare == {$past(io_wdata[7:6]), $past(io_wdata[1])};
  endproperty
  a_pressure: assert property (p_pressure) else $error("pressure flag not driven");

  property p_status_b;
    @(posedge sys_clk) disable iff (!rstn)
      (io_wr && hit_sb) |=> status_b == $past(io_wdata) && $stable(healthy_flag_n);
  endproperty
  a_status_b: assert property (p_status_b) else $error("status b write wrong");

  property p_unmapped;
    @(posedge sys_clk) disable iff (!rstn)
      (io_rd && !(hit_lo || hit_hi || hit_int)) |=> io_rdata == 8'hff;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not all ones");

  // valid follows each read strobe one cycle later and stays high as many cycles as the strobe
  property p_rvalid;
    @(posedge sys_clk) disable iff (!rstn)
      io_rvalid == $past(io_rd);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after read");

  // read data must hold between reads so a slow host can still pick it up
  property p_rd_hold;
    @(posedge sys_clk) disable iff (!rstn)
      !io_rd |=> $stable(io_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
endmodule : idio_top
`default_nettype wire

/* File: shared/idio_regs.svh */
// offsets, field positions, reset values and timing counts of the digital i/o block
`ifndef IDIO_REGS_SVH
`define IDIO_REGS_SVH
`define IDIO_ADDR_W          10
`define IDIO_ADDR_CTRL_LO    10'h321
`define IDIO_ADDR_INTERNAL   10'h322
`define IDIO_ADDR_STATUS_A   10'h323
`define IDIO_ADDR_STATUS_B   10'h324
`define IDIO_ADDR_CTRL_HI    10'h325
`define IDIO_IN_PAD          2'h3
`define IDIO_UNMAPPED_RD     8'hff
`define IDIO_RST_OUT8        8'hff
`define IDIO_RST_OUT4        4'hf
`define IDIO_RST_RELAY       16'hffff
`define IDIO_RLY_SAFE        16'hffff
`define IDIO_ST_HEALTHY      0
`define IDIO_ST_SEQ          2
`define IDIO_ST_DIAG         3
`define IDIO_ST_THERMAL      4
`define IDIO_ST_PRESSURE     5
`define IDIO_RLY_WATCHDOG    0
`define IDIO_RLY_VENT        1
`define IDIO_RLY_TUBE2_HEAT  2
`define IDIO_RLY_BYPASS      5
`define IDIO_RLY_METER_REF   6
`define IDIO_RLY_OZONE_SRC   7
`define IDIO_RLY_PUMP        8
`define IDIO_RLY_DIVERSION   9
`define IDIO_RLY_OUT_B       10
`define IDIO_RLY_TUBE1_VALVE 11
`define IDIO_RLY_TUBE2_VALVE 12
`define IDIO_RLY_TUBE1_HEAT  13
`define IDIO_RLY_METER_LAMP  14
`define IDIO_RLY_OZONE_LAMP  15
`define IDIO_RLY_VALVE_MASK  16'h1ea2
`define IDIO_RLY_HEAT_MASK   16'he004
`define IDIO_WD_TIME_S       5
`define IDIO_CLK_HZ          40000000
`define IDIO_WD_CYCLES       (`IDIO_WD_TIME_S * `IDIO_CLK_HZ)
`endif

/* File: shared/idio_pkg.sv */
// types and decode helper of the digital i/o block
`default_nettype none
package idio_pkg;
  typedef logic [7:0]  idio_byte_t;
  typedef logic [15:0] idio_word_t;
  typedef logic [9:0]  idio_addr_t;
  typedef enum logic [2:0] {
    IDIO_WD_IDLE = 3'b001,
    IDIO_WD_RUN  = 3'b010,
    IDIO_WD_TRIP = 3'b100
  } idio_wd_e;
  function automatic logic idio_hit(input idio_addr_t a, input idio_addr_t o);
    return a == o;
  endfunction : idio_hit
endpackage : idio_pkg
`default_nettype wire

/* File: shared/idio_wr_if.sv */
// write channel from the port decoder or the relay word inputs to the output register modules
`timescale 1ns/1ps
`default_nettype none
interface idio_wr_if #(parameter int W = 8);
  logic         we;
  logic [W-1:0] data;
  modport src (output we, output data);
  modport dst (input we, input data);
endinterface : idio_wr_if
`default_nettype wire

/* File: rtl/idio_status.sv */
// status output ports a and b
`timescale 1ns/1ps
`default_nettype none
`include "idio_regs.svh"
module idio_status (
  input  wire logic        sys_clk,   // system clock
  input  wire logic        rstn,      // async reset, low
  idio_wr_if.dst           wr_a,      // status port a write
  idio_wr_if.dst           wr_b,      // status port b write
  output idio_pkg::idio_byte_t status_a, // port a pins
  output idio_pkg::idio_byte_t status_b  // port b pins
);
  import idio_pkg::*;
  idio_byte_t a_q, a_d, b_q, b_d;

  always_comb begin
    a_d = wr_a.we ? wr_a.data : a_q;
    b_d = wr_b.we ? wr_b.data : b_q;
  end

  // reset to all ones: reports unhealthy and no activity until firmware speaks
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      a_q <= `IDIO_RST_OUT8;
      b_q <= `IDIO_RST_OUT8;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  assign status_a = a_q;
  assign status_b = b_q;
endmodule : idio_status
`default_nettype wire

/* File: rtl/idio_relay.sv */
// relay board output word with watchdog fallback
`timescale 1ns/1ps
`default_nettype none
`include "idio_regs.svh"
module idio_relay #(
  parameter int unsigned WD_CYCLES = `IDIO_WD_CYCLES
) (
  input  wire logic        sys_clk,     // system clock
  input  wire logic        rstn,        // async reset, low
  idio_wr_if.dst           wr,          // relay word write
  output idio_pkg::idio_word_t drive,   // relay board drives, low active
  output logic             wd_tripped   // watchdog expired
);
  import idio_pkg::*;
  localparam int CW = $clog2(WD_CYCLES + 1);
  localparam logic [CW-1:0] LIM = CW'(WD_CYCLES - 1);

  idio_wd_e   st_q, st_d;
  idio_word_t word_q, word_d, drive_q, drive_d;
  logic       wd_q, wd_d, toggle;
  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    toggle = wr.we && ((wr.data[`IDIO_RLY_WATCHDOG] != wd_q) || (st_q == IDIO_WD_IDLE));
    word_d = wr.we ? wr.data : word_q;
    wd_d   = wr.we ? wr.data[`IDIO_RLY_WATCHDOG] : wd_q;
    cnt_d  = cnt_q;
    st_d   = st_q;
    // a toggle in the expiry cycle still counts: far side met its deadline
    case (st_q)
      IDIO_WD_IDLE: if (toggle) begin
        st_d  = IDIO_WD_RUN;
        cnt_d = '0;
      end
      IDIO_WD_RUN: if (toggle) begin
        cnt_d = '0;
      end else if (cnt_q == LIM) begin
        st_d = IDIO_WD_TRIP;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
      IDIO_WD_TRIP: if (toggle) begin
        st_d  = IDIO_WD_RUN;
        cnt_d = '0;
      end
      default: st_d = IDIO_WD_IDLE;
    endcase
    drive_d = (st_d == IDIO_WD_TRIP) ? `IDIO_RLY_SAFE : word_d;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= IDIO_WD_IDLE;
      word_q  <= `IDIO_RST_RELAY;
      drive_q <= `IDIO_RST_RELAY;
      wd_q    <= 1'b1;
      cnt_q   <= '0;
    end else begin
      st_q    <= st_d;
      word_q  <= word_d;
      drive_q <= drive_d;
      wd_q    <= wd_d;
      cnt_q   <= cnt_d;
    end
  end

  assign drive      = drive_q;
  assign wd_tripped = (st_q == IDIO_WD_TRIP);

  property p_valves;
    @(posedge sys_clk) disable iff (!rstn)
      (wr.we && st_d != IDIO_WD_TRIP) |=>
        ((drive & `IDIO_RLY_VALVE_MASK) == ($past(wr.data) & `IDIO_RLY_VALVE_MASK));
  endproperty
  a_valves: assert property (p_valves) else $error("valve bits not passed");

  property p_heaters;
    @(posedge sys_clk) disable iff (!rstn)
      (wr.we && st_d != IDIO_WD_TRIP) |=>
        ((drive & `IDIO_RLY_HEAT_MASK) == ($past(wr.data) & `IDIO_RLY_HEAT_MASK));
  endproperty
  a_heaters: assert property (p_heaters) else $error("heater bits not passed");

  property p_meter_ref;
    @(posedge sys_clk) disable iff (!rstn)
      (wr.we && !wr.data[`IDIO_RLY_METER_REF] && st_d != IDIO_WD_TRIP) |=>
        !drive[`IDIO_RLY_METER_REF];
  endproperty
  a_meter_ref: assert property (p_meter_ref) else $error("reference select lost");

  property p_pump;
    @(posedge sys_clk) disable iff (!rstn)
      (wr.we && st_d != IDIO_WD_TRIP) |=>
        drive[`IDIO_RLY_PUMP] == $past(wr.data[`IDIO_RLY_PUMP]);
  endproperty
  a_pump: assert property (p_pump) else $error("pump bit not passed");

  property p_fallback;
    @(posedge sys_clk) disable iff (!rstn)
      (st_q == IDIO_WD_RUN && cnt_q == LIM && !toggle) |=>
        (drive == `IDIO_RLY_SAFE && wd_tripped) [*2];
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback on expiry");
endmodule : idio_relay
`default_nettype wire

/* File: tb/idio_far_end.sv */
// far-side model: external contacts, spare lines and the valve bank on the relay board
`timescale 1ns/1ps
`default_nettype none
`include "idio_regs.svh"
module idio_far_end (
  input  wire logic                 sys_clk,       // system clock
  input  wire logic [5:0]           lo_req,        // wanted contact levels 1-6
  input  wire logic [5:0]           hi_req,        // wanted contact levels 7-12
  input  wire idio_pkg::idio_byte_t int_req,       // wanted spare levels
  input  wire idio_pkg::idio_word_t relay_drive_n, // relay board drives
  output logic [5:0]                ctrl_in_lo_n,  // contacts 1-6, low closed
  output logic [5:0]                ctrl_in_hi_n,  // contacts 7-12, low closed
  output idio_pkg::idio_byte_t      int_in,        // spare lines
  output logic [4:0]                valves_open    // valves held open now
);
  import idio_pkg::*;
  // contacts move away from the sampling edge so the capture never races
  always @(negedge sys_clk) begin
    ctrl_in_lo_n <= lo_req;
    ctrl_in_hi_n <= hi_req;
    int_in       <= int_req;
  end
  // a valve coil is energised by a low drive
  always_comb valves_open = 5'($countones(~relay_drive_n & `IDIO_RLY_VALVE_MASK));
endmodule : idio_far_end
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the digital i/o ports
`timescale 1ns/1ps
`default_nettype none
`include "idio_regs.svh"
module testbench;
  import idio_pkg::*;
  // short watchdog so the expiry case fits in a brief run
  localparam int unsigned WD = 16;
  localparam logic [63:0] RST_SNAP = {2'h0, 8'hff, 4'hf, 8'hff, 8'hff, 8'hff, 16'hffff, 10'h0ff};
  typedef struct packed {
    logic       rel;
    idio_addr_t addr;
    idio_word_t data;
    idio_word_t exp;
  } idio_row_s;
  logic       sys_clk = 1'b0;
  logic       rstn, io_wr, io_rd, relay_we, io_rvalid, relay_wd_trip;
  logic       healthy_flag_n, sequence_running_n, diagnostics_active_n;
  logic       thermal_alarm_n, pressure_fault_n;
  logic [2:0] status_a_spare;
  logic [3:0] ctrl_out_hi_n;
  logic [4:0] valves_open;
  logic [5:0] lo_req, hi_req, ctrl_in_lo_n, ctrl_in_hi_n;
  idio_addr_t io_addr;
  idio_byte_t io_wdata, io_rdata, int_req, int_in, ctrl_out_lo_n, int_out, status_b, st_a;
  idio_word_t relay_wdata, relay_drive_n;
  idio_row_s  rows [15];
  int         fails = 0;
  int         checks = 0;
  int         cyc = 0;
  assign st_a = {status_a_spare[2:1], pressure_fault_n, thermal_alarm_n, diagnostics_active_n,
                 sequence_running_n, status_a_spare[0], healthy_flag_n};
  idio_top #(.WD_CYCLES(WD)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .ctrl_in_lo_n(ctrl_in_lo_n),
    .ctrl_in_hi_n(ctrl_in_hi_n), .int_in(int_in), .ctrl_out_lo_n(ctrl_out_lo_n),
    .ctrl_out_hi_n(ctrl_out_hi_n), .int_out(int_out), .healthy_flag_n(healthy_flag_n),
    .sequence_running_n(sequence_running_n), .diagnostics_active_n(diagnostics_active_n),
    .thermal_alarm_n(thermal_alarm_n), .pressure_fault_n(pressure_fault_n),
    .status_a_spare(status_a_spare), .status_b(status_b), .relay_we(relay_we),
    .relay_wdata(relay_wdata), .relay_drive_n(relay_drive_n), .relay_wd_trip(relay_wd_trip));
  idio_far_end far (
    .sys_clk(sys_clk), .lo_req(lo_req), .hi_req(hi_req), .int_req(int_req),
    .relay_drive_n(relay_drive_n), .ctrl_in_lo_n(ctrl_in_lo_n), .ctrl_in_hi_n(ctrl_in_hi_n),
    .int_in(int_in), .valves_open(valves_open));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic io_write(input idio_addr_t a, input idio_byte_t d);
    @(negedge sys_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge sys_clk);
    io_wr = 1'b0;
  endtask : io_write
  task automatic io_read(input idio_addr_t a, input idio_byte_t e);
    @(negedge sys_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge sys_clk);
    io_rd = 1'b0;
    chk({55'h0, io_rvalid, io_rdata}, {55'h0, 1'b1, e});
  endtask : io_read
  task automatic relay_write(input idio_word_t d);
    @(negedge sys_clk);
    relay_wdata = d;
    relay_we = 1'b1;
    @(negedge sys_clk);
    relay_we = 1'b0;
  endtask : relay_write
  function automatic idio_word_t view(input logic rel, input idio_addr_t a);
    if (rel) return relay_drive_n;
    case (a)
      `IDIO_ADDR_CTRL_LO:  return {8'h00, ctrl_out_lo_n};
      `IDIO_ADDR_CTRL_HI:  return {12'h000, ctrl_out_hi_n};
      `IDIO_ADDR_INTERNAL: return {8'h00, int_out};
      `IDIO_ADDR_STATUS_A: return {8'h00, st_a};
      default:             return {8'h00, status_b};
    endcase
  endfunction : view
  function automatic logic [63:0] snap();
    return {2'h0, ctrl_out_lo_n, ctrl_out_hi_n, int_out, st_a, status_b, relay_drive_n,
            relay_wd_trip, io_rvalid, io_rdata};
  endfunction : snap
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    rstn = 1'b0;
    {io_wr, io_rd, relay_we} = 3'h0;
    io_addr = '0;
    io_wdata = '0;
    relay_wdata = 16'hffff;
    {lo_req, hi_req, int_req} = 20'hfffff;
    rows = '{'{1'b0, `IDIO_ADDR_CTRL_LO, 16'h00a5, 16'h00a5},
             '{1'b0, `IDIO_ADDR_CTRL_LO, 16'h005a, 16'h005a},
             '{1'b0, `IDIO_ADDR_CTRL_HI, 16'h003c, 16'h000c},
             '{1'b0, `IDIO_ADDR_CTRL_HI, 16'h0003, 16'h0003},
             '{1'b0, `IDIO_ADDR_INTERNAL, 16'h00c3, 16'h00c3},
             '{1'b0, `IDIO_ADDR_STATUS_A, 16'h00fe, 16'h00fe},
             '{1'b0, `IDIO_ADDR_STATUS_A, 16'h0001, 16'h0001},
             '{1'b0, `IDIO_ADDR_STATUS_A, 16'h00aa, 16'h00aa},
             '{1'b0, `IDIO_ADDR_STATUS_A, 16'h0055, 16'h0055},
             '{1'b0, `IDIO_ADDR_STATUS_B, 16'h0096, 16'h0096},
             '{1'b1, 10'h000, 16'hfffe, 16'hfffe},
             '{1'b1, 10'h000, 16'he15d, 16'he15d},
             '{1'b1, 10'h000, 16'h1ffa, 16'h1ffa},
             '{1'b1, 10'h000, 16'hffbf, 16'hffbf},
             '{1'b1, 10'h000, 16'hfefe, 16'hfefe}};
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    chk(snap(), RST_SNAP);
    $display("test reset values done");
    foreach (rows[i]) begin
      if (rows[i].rel) relay_write(rows[i].data);
      else io_write(rows[i].addr, rows[i].data[7:0]);
      chk({48'h0, view(rows[i].rel, rows[i].addr)}, {48'h0, rows[i].exp});
    end
    $display("test port table done");
    lo_req = 6'h2a;
    hi_req = 6'h15;
    int_req = 8'h69;
    repeat (2) @(negedge sys_clk);
    io_read(`IDIO_ADDR_CTRL_LO, 8'hea);
    io_read(`IDIO_ADDR_CTRL_HI, 8'hd5);
    io_read(`IDIO_ADDR_INTERNAL, 8'h69);
    io_read(`IDIO_ADDR_STATUS_A, 8'hff);
    io_read(`IDIO_ADDR_STATUS_B, 8'hff);
    io_read(10'h320, 8'hff);
    @(negedge sys_clk);
    chk({63'h0, io_rvalid}, 64'h0);
    $display("test reads done");
    // three writes on consecutive edges, the last to a hole in the map
    @(negedge sys_clk);
    io_addr = `IDIO_ADDR_CTRL_LO;
    io_wdata = 8'h11;
    io_wr = 1'b1;
    @(negedge sys_clk);
    io_addr = `IDIO_ADDR_CTRL_HI;
    io_wdata = 8'h02;
    @(negedge sys_clk);
    io_addr = 10'h320;
    io_wdata = 8'h00;
    @(negedge sys_clk);
    io_wr = 1'b0;
    chk({36'h0, ctrl_out_lo_n, ctrl_out_hi_n, int_out, status_b},
        {36'h0, 8'h11, 4'h2, 8'hc3, 8'h96});
    $display("test back to back done");
    for (int i = 0; i < 5; i++) begin
      relay_write({15'h3a5a, ~i[0]});
      repeat (WD / 2) @(negedge sys_clk);
    end
    chk({42'h0, relay_wd_trip, valves_open, relay_drive_n}, {42'h0, 1'b0, 5'd3, 16'h74b5});
    repeat (WD + 4) @(negedge sys_clk);
    chk({42'h0, relay_wd_trip, valves_open, relay_drive_n}, {42'h0, 1'b1, 5'd0, 16'hffff});
    relay_write(16'h0f05);
    chk({47'h0, relay_wd_trip, relay_drive_n}, {47'h0, 1'b1, 16'hffff});
    relay_write(16'h0f04);
    @(negedge sys_clk);
    chk({47'h0, relay_wd_trip, relay_drive_n}, {47'h0, 1'b0, 16'h0f04});
    $display("test watchdog done");
    @(negedge sys_clk);
    rstn = 1'b0;
    #1;
    chk(snap(), RST_SNAP);
    @(negedge sys_clk);
    rstn = 1'b1;
    // no relay write since reset, so the watchdog must stay idle
    repeat (WD + 4) @(negedge sys_clk);
    chk({47'h0, relay_wd_trip, relay_drive_n}, {47'h0, 1'b0, 16'hffff});
    $display("test second reset done");
    // a toggle landing on the expiry edge itself still keeps the board alive
    relay_write(16'h7ffe);
    repeat (WD - 1) @(negedge sys_clk);
    chk({47'h0, relay_wd_trip, relay_drive_n}, {47'h0, 1'b0, 16'h7ffe});
    relay_wdata = 16'h7fff;
    relay_we = 1'b1;
    @(negedge sys_clk);
    relay_we = 1'b0;
    chk({47'h0, relay_wd_trip, relay_drive_n}, {47'h0, 1'b0, 16'h7fff});
    $display("test expiry edge done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
